// [hw/secl_config_loader.sv]
// Strap capture, serial-memory configuration load and pin function selection.
// Assumes: straps and pins are asynchronous to clk; wake_event comes from clk-domain logic.
// Functional notes
// [R1] Strap levels are captured during reset and select mode and pin setup.
// [R2] Wake strap low gives normal operation, high gives wake-ready mode after reset.
// [R3] Swap strap low keeps the high-speed pairs as wired, high swaps both pairs.
// [R4] Bit 4 of the flag word at memory word 05h makes general pin zero the wake output.
// [R5] As general I/O, pin zero is driven and read only through host vendor registers.
// [R6] Each of the four multi-function pins is an LED or a general I/O per its enable bit.
// [R7] LED defaults are SuperSpeed, link plus activity, link speed, activity; word 42h tunes.
// [R8] Memory data is used only when the low byte of word 05h is 0xFF minus words 03h+04h.
// [R9] After reset the loader reads the memory by itself, with no host command.
// [R10] The external active-low reset acts exactly like the internal power-on reset.
// [R11] A new external reset re-enters wake-ready mode if the wake strap is high.
// [R12] Wake-ready mode turns the USB transceiver off but keeps detector and PHY running.
// [R13] Captured straps stay fixed from reset release until the next reset.
`timescale 1ns/10ps

module secl_config_loader
  import secl_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ext_reset_n,
  // Strap pins
  input  wire logic                strap_wake_in,
  input  wire logic                strap_swap_in,
  // Serial memory
  output secl_pkg::secl_eeprom_t   eeprom_pins,
  input  wire logic                eeprom_do_in,
  // General pin zero
  input  wire logic                gpio0_in,
  output logic                     gpio0_out,
  output logic                     gpio0_oe,
  // Multi-function pins
  input  wire logic [3:0]          mf_pin_in,
  output logic [3:0]               mf_pin_out,
  output logic [3:0]               mf_pin_oe,
  input  wire logic [3:0]          led_src,
  // Wake logic and mode outputs
  input  wire logic                wake_event,
  output logic                     power_event_output,
  output logic                     default_wake_ready_mode,
  output logic                     lane_swap,
  output logic                     usb_xcvr_enable,
  output logic                     magic_detect_enable,
  output logic                     phy_autoneg_enable,
  output logic                     wake_output_pin_select,
  output logic [15:0]              led_mode_word,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import secl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [8:0]   pin_meta_reg;
  logic [8:0]   pin_sync_reg;
  logic         sys_rst;
  logic         ext_n_sync;
  logic         wake_sync;
  logic         swap_sync;
  logic         do_sync;
  logic         g0_sync;
  logic [3:0]   mf_sync;

  always_ff @(posedge clk) begin
    pin_meta_reg <= {ext_reset_n, strap_wake_in, strap_swap_in, eeprom_do_in, gpio0_in,
                     mf_pin_in};
    pin_sync_reg <= pin_meta_reg;
  end

  assign {ext_n_sync, wake_sync, swap_sync, do_sync, g0_sync, mf_sync} = pin_sync_reg;
  // [R10] External reset merged
  assign sys_rst = reset | ~ext_n_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture
  logic wake_strap_reg;
  logic swap_strap_reg;

  // [R1] [R3] [R13] Track straps only while in reset, then hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_strap_reg <= wake_sync;
      swap_strap_reg <= swap_sync;
    end
  end

  assign lane_swap = swap_strap_reg;

  a_strap_hold_stable: assert property (@(posedge clk) disable iff (sys_rst)
    $past(!sys_rst) |-> $stable(wake_strap_reg) && $stable(swap_strap_reg))
    else $error("Captured strap changed outside reset"); // [R13]

  a_strap_swap_capture: assert property (@(posedge clk) disable iff (reset)
    $fell(sys_rst) |-> lane_swap == $past(swap_sync))
    else $error("Swap strap not captured at reset release"); // [R3]

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode
  logic wake_mode_reg;
  logic power_event_reg;
  logic usb_en_reg;
  logic run_reg;

  // [R2] [R11] Mode follows strap at every reset; a wake event ends wake-ready mode only when pin zero is the wake output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_mode_reg <= wake_sync;
    end else if (power_event_reg) begin
      wake_mode_reg <= 1'b0;
    end
  end

  // Static level output, held until the next reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_event_reg <= 1'b0;
    end else if (wake_event && wake_output_pin_select) begin
      power_event_reg <= 1'b1;
    end
  end

  // [R12] USB side off in wake-ready mode; PHY and detector stay up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      usb_en_reg <= 1'b0;
      run_reg    <= 1'b0;
    end else begin
      usb_en_reg <= ~wake_mode_reg;
      run_reg    <= 1'b1;
    end
  end

  assign default_wake_ready_mode = wake_mode_reg;
  assign usb_xcvr_enable         = usb_en_reg;
  assign magic_detect_enable     = run_reg;
  assign phy_autoneg_enable      = run_reg;
  assign power_event_output      = power_event_reg;

  a_wake_mode_entry: assert property (@(posedge clk) disable iff (reset)
    $fell(sys_rst) |-> default_wake_ready_mode == wake_strap_reg)
    else $error("Mode after reset does not follow wake strap"); // [R2]

  a_usb_off_wake: assert property (@(posedge clk) disable iff (sys_rst)
    default_wake_ready_mode ##1 default_wake_ready_mode |->
      !usb_xcvr_enable && magic_detect_enable && phy_autoneg_enable)
    else $error("USB on or PHY off during wake-ready mode"); // [R12]

  ////////////////////////////////////////////////////////////////////////////
  // Serial memory loader
  secl_state_t  state_reg;
  logic [7:0]   half_cnt_reg;
  logic [4:0]   bit_cnt_reg;
  logic [1:0]   word_idx_reg;
  logic [15:0]  word_reg [4];
  logic [16:0]  shift_reg;
  logic         cfg_valid_reg;
  logic [15:0]  flag_reg;
  logic [15:0]  led_reg;
  logic         half_tick;
  logic [7:0]   word_addr;
  logic [10:0]  cmd_word;
  logic [7:0]   sum_low;
  logic         sum_ok;

  assign half_tick = (half_cnt_reg == SK_HALF_CYC - 8'h01);

  always_comb begin
    unique case (word_idx_reg)
      2'h0: word_addr = ADDR_SUM_LO;
      2'h1: word_addr = ADDR_SUM_HI;
      2'h2: word_addr = ADDR_FLAG;
      2'h3: word_addr = ADDR_LED;
    endcase
  end

  assign cmd_word = {CMD_READ, word_addr};
  // [R8] Checksum over the two words, modulo 256
  assign sum_low  = word_reg[0][7:0] + word_reg[1][7:0];
  assign sum_ok   = (word_reg[2][7:0] == CHECK_BASE - sum_low);

  always_ff @(posedge clk) begin
    if (sys_rst || half_tick || state_reg == ST_DONE) begin
      half_cnt_reg <= 8'h00;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  // [R9] Sequence starts by itself right after reset release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg    <= ST_SELECT;
      eeprom_pins  <= '0;
      bit_cnt_reg  <= 5'h00;
      word_idx_reg <= 2'h0;
      shift_reg    <= 17'h0_0000;
    end else if (half_tick) begin
      unique case (state_reg)
        ST_SELECT: begin
          eeprom_pins.cs <= 1'b1;
          eeprom_pins.di <= cmd_word[10];
          bit_cnt_reg    <= 5'h00;
          state_reg      <= ST_CMD;
        end
        ST_CMD: begin
          eeprom_pins.sk <= ~eeprom_pins.sk;
          if (eeprom_pins.sk) begin
            if (bit_cnt_reg == 5'(CMD_BITS - 4'h1)) begin
              bit_cnt_reg    <= 5'h00;
              eeprom_pins.di <= 1'b0;
              state_reg      <= ST_DATA;
            end else begin
              bit_cnt_reg    <= bit_cnt_reg + 5'h01;
              eeprom_pins.di <= cmd_word[4'hA - 4'(bit_cnt_reg + 5'h01)];
            end
          end
        end
        ST_DATA: begin
          eeprom_pins.sk <= ~eeprom_pins.sk;
          // Sample at the end of the high phase, long after the memory has settled
          if (eeprom_pins.sk) begin
            shift_reg   <= {shift_reg[15:0], do_sync};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == DATA_BITS - 5'h01) begin
              state_reg <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // Chip select low for two half periods between reads ends the read cycle
          if (eeprom_pins.cs) begin
            eeprom_pins.cs <= 1'b0;
          end else if (word_idx_reg == LAST_WORD) begin
            state_reg <= ST_CHECK;
          end else begin
            word_idx_reg <= word_idx_reg + 2'h1;
            state_reg    <= ST_SELECT;
          end
        end
        ST_CHECK: begin
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_SELECT;
        end
      endcase
    end
  end

  // Words stored by index as each read completes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        word_reg[i] <= 16'h0000;
      end
    end else if (state_reg == ST_GAP && eeprom_pins.cs) begin
      word_reg[word_idx_reg] <= shift_reg[15:0];
    end
  end

  // [R8] Memory content applied only when the checksum matches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_valid_reg <= 1'b0;
      flag_reg      <= FLAG_DEFAULT;
      led_reg       <= LED_DEFAULT;
    end else if (state_reg == ST_CHECK && half_tick) begin
      cfg_valid_reg <= sum_ok;
      flag_reg      <= sum_ok ? word_reg[2] : FLAG_DEFAULT;
      led_reg       <= sum_ok ? word_reg[3] : LED_DEFAULT;
    end
  end

  assign led_mode_word          = led_reg;
  assign wake_output_pin_select = flag_reg[PIN_SEL_BIT];

  a_load_auto_start: assert property (@(posedge clk) disable iff (reset)
    $fell(sys_rst) |-> ##[1:60] eeprom_pins.cs)
    else $error("Loader did not start after reset"); // [R9]

  a_checksum_accept: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == ST_CHECK && half_tick) |=>
      (cfg_valid_reg == $past(sum_ok)) && (state_reg == ST_DONE))
    else $error("Checksum decision wrong"); // [R8]

  a_pin_select_bit: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == ST_DONE) |-> wake_output_pin_select == (cfg_valid_reg ?
      word_reg[2][PIN_SEL_BIT] : FLAG_DEFAULT[PIN_SEL_BIT]))
    else $error("Pin zero function not from flag bit"); // [R4]

  a_ext_reset_equiv: assert property (@(posedge clk) disable iff (reset)
    !ext_n_sync |=> (state_reg == ST_SELECT) && !power_event_reg && !eeprom_pins.cs)
    else $error("External reset did not reset the loader"); // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Pin function selection
  logic         g0_out_ctl_reg;
  logic         g0_oe_ctl_reg;
  secl_mf_ctl_t mf_ctl_reg;
  logic         g0_out_reg;
  logic         g0_oe_reg;
  logic [3:0]   mf_out_reg;
  logic [3:0]   mf_oe_reg;

  // [R4] [R5] Wake output or host-controlled I/O on pin zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      g0_out_reg <= 1'b0;
      g0_oe_reg  <= 1'b0;
    end else if (wake_output_pin_select) begin
      g0_out_reg <= power_event_reg;
      g0_oe_reg  <= 1'b1;
    end else begin
      g0_out_reg <= g0_out_ctl_reg;
      g0_oe_reg  <= g0_oe_ctl_reg;
    end
  end

  assign gpio0_out = g0_out_reg;
  assign gpio0_oe  = g0_oe_reg;

  // [R6] [R7] Per pin: LED source, highest pin SuperSpeed down to activity
  for (genvar p = 0; p < 4; p++) begin : g_mf_pin
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mf_out_reg[p] <= 1'b0;
        mf_oe_reg[p]  <= 1'b0;
      end else if (mf_ctl_reg.enable[p]) begin
        mf_out_reg[p] <= mf_ctl_reg.io_out[p];
        mf_oe_reg[p]  <= mf_ctl_reg.io_oe[p];
      end else begin
        mf_out_reg[p] <= led_src[p];
        mf_oe_reg[p]  <= 1'b1;
      end
    end
  end

  assign mf_pin_out = mf_out_reg;
  assign mf_pin_oe  = mf_oe_reg;

  a_gpio_vendor_ctl: assert property (@(posedge clk) disable iff (sys_rst)
    !wake_output_pin_select |=> gpio0_out == $past(g0_out_ctl_reg) &&
      gpio0_oe == $past(g0_oe_ctl_reg))
    else $error("Pin zero not under host control"); // [R5]

  a_mf_select: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> mf_pin_out == $past((mf_ctl_reg.enable & mf_ctl_reg.io_out) |
      (~mf_ctl_reg.enable & led_src)))
    else $error("Multi-function pin source wrong"); // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic         aw_hold_reg;
  logic         w_hold_reg;
  logic [11:0]  awaddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;
  logic         do_write;
  logic [31:0]  rd_mux;
  logic         rd_hit;

  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign do_write      = aw_hold_reg & w_hold_reg & ~bvalid_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
    end
  end

  // Host vendor registers, byte lanes honoured
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      g0_out_ctl_reg <= 1'b0;
      g0_oe_ctl_reg  <= 1'b0;
      mf_ctl_reg     <= '0;
    end else if (do_write && wstrb_reg[0]) begin
      if (awaddr_reg == REG_GPIO0) begin
        g0_out_ctl_reg <= wdata_reg[G0_OUT_BIT];
        g0_oe_ctl_reg  <= wdata_reg[G0_OE_BIT];
      end else if (awaddr_reg == REG_MF_CTRL) begin
        mf_ctl_reg.enable <= wdata_reg[MF_EN_LSB +: 4];
      end
    end
    if (!sys_rst && do_write && awaddr_reg == REG_MF_CTRL) begin
      if (wstrb_reg[1]) begin
        mf_ctl_reg.io_out <= wdata_reg[MF_OUT_LSB +: 4];
      end
      if (wstrb_reg[2]) begin
        mf_ctl_reg.io_oe <= wdata_reg[MF_OE_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (awaddr_reg == REG_GPIO0 || awaddr_reg == REG_MF_CTRL ||
                     awaddr_reg == REG_STATUS || awaddr_reg == REG_FLAG ||
                     awaddr_reg == REG_LED_MODE) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      REG_STATUS: begin
        rd_mux[ST_DONE_BIT]  = (state_reg == ST_DONE);
        rd_mux[ST_VALID_BIT] = cfg_valid_reg;
        rd_mux[ST_WAKE_BIT]  = wake_mode_reg;
        rd_mux[ST_SWAP_BIT]  = swap_strap_reg;
        rd_mux[ST_EVENT_BIT] = power_event_reg;
        rd_mux[ST_PSEL_BIT]  = wake_output_pin_select;
        rd_mux[ST_BUSY_BIT]  = (state_reg != ST_DONE);
      end
      REG_FLAG:     rd_mux[15:0] = flag_reg;
      REG_LED_MODE: rd_mux[15:0] = led_reg;
      REG_GPIO0: begin
        rd_mux[G0_OUT_BIT] = g0_out_ctl_reg;
        rd_mux[G0_OE_BIT]  = g0_oe_ctl_reg;
        rd_mux[G0_IN_BIT]  = g0_sync;
      end
      REG_MF_CTRL: begin
        rd_mux[MF_EN_LSB +: 4]  = mf_ctl_reg.enable;
        rd_mux[MF_OUT_LSB +: 4] = mf_ctl_reg.io_out;
        rd_mux[MF_OE_LSB +: 4]  = mf_ctl_reg.io_oe;
        rd_mux[MF_IN_LSB +: 4]  = mf_sync;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule // secl_config_loader

// [hw/secl_pkg.sv]
// Shared constants and types of the strap and serial-memory configuration loader.
// Assumes a 100 MHz core clock and a three-wire 16-bit serial memory with 8-bit addressing.
package secl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_FREQ_MHZ = 100;
  // Least half period of the serial memory clock, in ns
  localparam int SK_HALF_NS   = 500;
  localparam logic [7:0] SK_HALF_CYC = 8'((SK_HALF_NS * CLK_FREQ_MHZ + 999) / 1000);

  ////////////////////////////////////////////////////////////////////////////
  // Serial memory layout and protocol
  localparam logic [7:0]  ADDR_SUM_LO  = 8'h03;
  localparam logic [7:0]  ADDR_SUM_HI  = 8'h04;
  localparam logic [7:0]  ADDR_FLAG    = 8'h05;
  localparam logic [7:0]  ADDR_LED     = 8'h42;
  localparam logic [2:0]  CMD_READ     = 3'h6;   // Start bit then read opcode
  localparam logic [3:0]  CMD_BITS     = 4'hB;
  localparam logic [4:0]  DATA_BITS    = 5'h11;  // Dummy zero plus 16 data bits
  localparam logic [1:0]  LAST_WORD    = 2'h3;
  localparam logic [7:0]  CHECK_BASE   = 8'hFF;
  localparam int          PIN_SEL_BIT  = 4;
  localparam logic [15:0] FLAG_DEFAULT = 16'h0000;
  localparam logic [15:0] LED_DEFAULT  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [11:0] REG_STATUS   = 12'h000;
  localparam logic [11:0] REG_FLAG     = 12'h004;
  localparam logic [11:0] REG_LED_MODE = 12'h008;
  localparam logic [11:0] REG_GPIO0    = 12'h00C;
  localparam logic [11:0] REG_MF_CTRL  = 12'h010;
  // Status fields
  localparam int ST_DONE_BIT  = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_WAKE_BIT  = 2;
  localparam int ST_SWAP_BIT  = 3;
  localparam int ST_EVENT_BIT = 4;
  localparam int ST_PSEL_BIT  = 5;
  localparam int ST_BUSY_BIT  = 6;
  // General pin zero fields
  localparam int G0_OUT_BIT = 0;
  localparam int G0_OE_BIT  = 1;
  localparam int G0_IN_BIT  = 8;
  // Multi-function pin fields, one nibble each
  localparam int MF_EN_LSB  = 0;
  localparam int MF_OUT_LSB = 8;
  localparam int MF_OE_LSB  = 16;
  localparam int MF_IN_LSB  = 24;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_SELECT = 3'b000,
    ST_CMD    = 3'b001,
    ST_DATA   = 3'b010,
    ST_GAP    = 3'b011,
    ST_CHECK  = 3'b100,
    ST_DONE   = 3'b101
  } secl_state_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } secl_eeprom_t;

  typedef struct packed {
    logic [3:0] io_oe;
    logic [3:0] io_out;
    logic [3:0] enable;
  } secl_mf_ctl_t;

endpackage

// [testbench/secl_config_loader_tb.sv]
// Self-checking bench of the configuration loader with a serial memory model.
// Assumes registers answer over AXI4-Lite within 100 cycles.
`timescale 1ns/10ps
module secl_config_loader_tb;
  import secl_pkg::*;
  logic         clk, reset, ext_reset_n, sw, ss, gin, wev, do_in, pev, dwm, lsw, usbx;
  logic         awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, g_out, g_oe, mde, pae, psel;
  logic [3:0]   mf_in, mf_out, mf_oe, led;
  logic [11:0]  awa, ara;
  logic [31:0]  wd, rd, rnd;
  logic [1:0]   bresp, rresp;
  logic [15:0]  led_w;
  secl_eeprom_t ee;
  int           failures, compares;
  secl_config_loader i_dut (.clk(clk), .reset(reset), .ext_reset_n(ext_reset_n),
    .strap_wake_in(sw), .strap_swap_in(ss), .eeprom_pins(ee), .eeprom_do_in(do_in),
    .gpio0_in(gin), .gpio0_out(g_out), .gpio0_oe(g_oe), .mf_pin_in(mf_in), .mf_pin_out(mf_out),
    .mf_pin_oe(mf_oe), .led_src(led), .wake_event(wev), .power_event_output(pev),
    .default_wake_ready_mode(dwm), .lane_swap(lsw), .usb_xcvr_enable(usbx),
    .magic_detect_enable(mde), .phy_autoneg_enable(pae), .wake_output_pin_select(psel),
    .led_mode_word(led_w), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  secl_eeprom_model i_mem (.cs(ee.cs), .sk(ee.sk), .di(ee.di), .do_out(do_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    hb = 1'b0;
    for (int n = 0; n < 100 && !hb; n++) begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr_r;
      hb = bv;
      r = bresp;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end
    br <= 1'b0;
    @(posedge clk);
    if (!hb) begin
      failures++;
      finish_test;
    end
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    hr = 1'b0;
    for (int n = 0; n < 100 && !hr; n++) begin
      @(negedge clk);
      ha = arv && arr;
      hr = rv;
      d = rd;
      r = rresp;
      @(posedge clk);
      if (ha) arv <= 1'b0;
    end
    rr <= 1'b0;
    @(posedge clk);
    if (!hr) begin
      failures++;
      finish_test;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One power-up: k=1 spoils the checksum, k=2 resets through the pin
  task automatic load(input int k);
    logic [15:0] w3, w4, w5;
    logic [7:0]  c;
    logic        v, wk, sp, ps;
    logic [31:0] d, e;
    logic [1:0]  r;
    int          n;
    rnd = lfsr(rnd);
    w3 = rnd[15:0];
    w4 = rnd[31:16];
    rnd = lfsr(rnd);
    c = 8'hFF - (w3[7:0] + w4[7:0]);
    if (k != 1 && !c[4]) begin
      w3 = w3 + 16'h0010;
      c = c - 8'h10;
    end
    w5 = {rnd[31:24], c ^ 8'(k == 1)};
    v = (k != 1);
    {wk, sp} = rnd[1:0];
    if (k == 2) wk = 1'b1;
    i_mem.mem[8'h03] = w3;
    i_mem.mem[8'h04] = w4;
    i_mem.mem[8'h05] = w5;
    i_mem.mem[8'h42] = rnd[23:8];
    sw <= wk;
    ss <= sp;
    gin <= rnd[2];
    led <= rnd[6:3];
    mf_in <= rnd[30:27];
    repeat (3) @(posedge clk);
    if (k == 2) ext_reset_n <= 1'b0;
    else reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    ext_reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (n = 0; n < 8000; n++) begin
      rd_reg(REG_STATUS, d, r);
      if (d[ST_DONE_BIT] === 1'b1) break;
    end
    if (n == 8000) begin
      failures++;
      finish_test;
    end
    ps = v & w5[PIN_SEL_BIT];
    e = 32'(1) | 32'(v) << ST_VALID_BIT | 32'(wk) << ST_WAKE_BIT | 32'(sp) << ST_SWAP_BIT;
    chk("status", d, e | 32'(ps) << ST_PSEL_BIT);
    rd_reg(REG_FLAG, d, r);
    chk("flag", d, v ? 32'(w5) : 32'h0000_0000);
    rd_reg(REG_LED_MODE, d, r);
    chk("led_mode", d, v ? 32'(rnd[23:8]) : 32'h0000_0000);
    chk("led_word", 32'(led_w), v ? 32'(rnd[23:8]) : 32'h0000_0000);
    chk("mode_pins", 32'({lsw, dwm, usbx, mde, pae, psel}), 32'({sp, wk, ~wk, 2'b11, ps}));
    sw <= ~wk;
    ss <= ~sp;
    repeat (4) @(posedge clk);
    chk("straps_held", 32'({lsw, dwm}), 32'({sp, wk}));
    wr_reg(REG_GPIO0, 32'h0000_0003, r);
    rd_reg(REG_GPIO0, d, r);
    chk("gpio0", d, 32'(gin) << G0_IN_BIT | 32'h0000_0003);
    chk("gpio0_pin", 32'({g_out, g_oe}), ps ? 32'h0000_0001 : 32'h0000_0003);
    rnd = lfsr(rnd);
    e = rnd & 32'h000F_0F0F;
    wr_reg(REG_MF_CTRL, e, r);
    rd_reg(REG_MF_CTRL, d, r);
    chk("mf_ctrl", d, e | 32'(mf_in) << MF_IN_LSB);
    chk("mf_out", 32'(mf_out), 32'((e[3:0] & e[11:8]) | (~e[3:0] & led)));
    chk("mf_oe", 32'(mf_oe & e[3:0]), 32'(e[19:16] & e[3:0]));
    wr_reg(12'h100, rnd, r);
    chk("wr_unmapped", 32'(r), 32'(RESP_SLVERR));
    rd_reg(12'h104, d, r);
    chk("rd_unmapped", d | 32'(r), 32'(RESP_SLVERR));
    wev <= 1'b1;
    @(posedge clk);
    wev <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wake_out", 32'({pev, dwm, usbx}), 32'({ps, wk & ~ps, ~(wk & ~ps)}));
  endtask
  initial begin
    {reset, ext_reset_n, sw, ss, gin, wev, awv, wv, br, arv, rr} <= 11'b110_0000_0000;
    {awa, ara, wd, mf_in, led, failures, compares} = '0;
    rnd = 32'h5e09;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 3; k++) load(k);
    finish_test;
  end
endmodule // secl_config_loader_tb

// [testbench/secl_eeprom_model.sv]
// Behavioural three-wire serial memory, 256 words of 16 bits.
// Assumes the bench fills mem before the loader reads it.
`timescale 1ns/10ps
module secl_eeprom_model (
  // Memory pins
  input  wire logic cs,
  input  wire logic sk,
  input  wire logic di,
  output logic      do_out
);
  logic [15:0] mem [0:255];
  logic [10:0] cmd;
  logic [15:0] sh;
  int          cnt;
  initial do_out = 1'b0;
  // Deselected output drifts, so a stale bit can never pass for data
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      cnt = 0;
      do_out = ~do_out;
    end else begin
      if (cnt < 11) cmd = {cmd[9:0], di};
      if (cnt == 10) sh = (cmd[10:8] == 3'b110) ? mem[cmd[7:0]] : ~mem[cmd[7:0]];
      if (cnt == 11) do_out = 1'b0;
      else if (cnt > 11 && cnt < 28) begin
        do_out = sh[15];
        sh = {sh[14:0], 1'b0};
      end
      cnt++;
    end
  end
endmodule // secl_eeprom_model
